//--- rtl/system_timers_two_to_five.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "system_timers_regs.svh"
// Notes on behaviour
// [R1] Reload mode: count up, flag, reload on overflow
// [R2] Capture mode: flag overflow, capture on trigger edge
// [R3] Baud mode forces reload, overflows clock serial
// [R4] Run bit clear stops the first timer
// [R5] No overflow flag in baud mode; software clears
// [R6] Baud selects choose first or legacy timer
// [R7] Trigger flag set on falling edge when enabled
// [R8] Software keeps trigger enable at zero
// [R9] Count source picks pin events or internal clock
// [R10] Timers c and d: 16-bit, system clocked
// [R11] Overflow flags set by hardware, software clears
// [R12] Mode bit picks reload or free wrap
// [R13] Simple timers advance only while run set
// [R14] Interrupt enable gates the overflow request
// [R15] Byte write hits reload or live counter
// [R16] Reads return live count, no snapshot
// [R17] Timer e: 24-bit, same write behaviour
// [R18] Timer e counts from oscillator, not system clock
// [R19] Clock select: fast osc 0x, slow osc 1x
// [R20] Timer e flag, mode, run, interrupt enable
// [R21] Internal clock divides by 12, 4 or 2
// [R22] Count pin sampled each clock, falling edges
// [R23] Divide select: 4 when set, 12 default
// [R24] Overflow is the step from all ones, one-clock event
// [R25] Interrupt line is flag and enable together; timer b ORs its two flags, no enable
module system_timers_two_to_five (
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    reset,
   // APB register bus
   input  wire system_timers_pkg::apb_req_t apb_req,
   output      system_timers_pkg::apb_rsp_t apb_rsp,
   // First timer pins
   input  wire logic                    tmr_b_count_pin,
   input  wire logic                    ext_trigger_pin,
   // Serial port baud clocking
   input  wire logic                    legacy_timer_overflow,
   output      logic                    rx_baud_tick,
   output      logic                    tx_baud_tick,
   // Oscillator levels for the 24-bit timer
   input  wire logic                    fast_internal_osc,
   input  wire logic                    slow_internal_osc,
   // Interrupt requests
   output      system_timers_pkg::timer_irq_t irq
);
   import system_timers_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // One count step; bit 16 flags the wrap
   function automatic logic [16:0] step16(input logic [15:0] cnt, input logic [15:0] rld,
                                          input logic do_reload);
      logic [16:0] res;
      res = {1'b0, cnt + 16'h0001};
      if (cnt == 16'hffff) begin
         res = {1'b1, (do_reload ? rld : 16'h0000)};
      end
      return res;
   endfunction

   // Replace one byte of a 16-bit value
   function automatic logic [15:0] put_byte16(input logic [15:0] val, input logic [7:0] b,
                                              input logic hi);
      logic [15:0] res;
      res = hi ? {b, val[7:0]} : {val[15:8], b};
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // APB decode

   logic [15:0]   idx;          // Register index from the byte address
   logic          access;       // Access phase of any transfer
   logic          wr;           // Write taken this cycle
   logic [7:0]    wbyte;        // Written byte, low lane
   logic          mapped;       // Index names a register
   logic [7:0]    rbyte;        // Read mux result

   assign idx    = apb_req.paddr[17:2];
   assign access = apb_req.psel && apb_req.penable;
   assign wr     = access && apb_req.pwrite && mapped;
   assign wbyte  = apb_req.pwdata[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   tmr_b_ctrl_t   tb_ctrl;      // First timer control
   logic          tb_div_sel;   // First timer fast prescale select
   logic [15:0]   tb_count;     // First timer live count
   logic [15:0]   tb_reload;    // Reload or capture pair
   logic [3:0]    tb_prescale;  // Internal clock prescaler
   logic          tb_pin_prev;  // Count pin, last sample
   logic          trig_prev;    // Trigger pin, last sample
   tmr_c_d_ctrl_t cd_ctrl;      // Shared control of timers c and d
   logic [15:0]   cd_count [2]; // Index 0 is timer c, 1 is timer d
   logic [15:0]   cd_reload [2];
   tmr_e_ctrl_t   te_ctrl;      // 24-bit timer control
   logic [23:0]   te_count;     // 24-bit live count
   logic [23:0]   te_reload;    // 24-bit reload value
   logic          fast_prev;    // Oscillator levels, last sample
   logic          slow_prev;

   ////////////////////////////////////////////////////////////////////////////
   // First timer mode and tick

   tmr_b_mode_t   tb_mode;
   logic [3:0]    tb_div;
   logic          tb_tick;
   logic [16:0]   tb_step;
   logic          tb_ovf;
   logic          trig_fall;

   // Mode from run, baud selects and capture select
   always_comb begin
      // [R4] run bit gates
      if (!tb_ctrl.run) begin
         tb_mode = tb_stopped;
      // [R3] baud overrides capture
      end else if (tb_ctrl.rx_baud_source_sel || tb_ctrl.tx_baud_source_sel) begin
         tb_mode = tb_baud;
      end else if (tb_ctrl.capture_reload_sel) begin
         tb_mode = tb_capture;
      end else begin
         tb_mode = tb_auto_reload;
      end
   end

   // [R21] [R23] prescale ratio choice
   assign tb_div = (tb_mode == tb_baud) ? `TMR_B_DIV_BAUD :
                   (tb_div_sel ? `TMR_B_DIV_FAST : `TMR_B_DIV_STD);

   // [R9] [R22] source of count events
   assign tb_tick = (tb_mode != tb_stopped) &&
                    (tb_ctrl.count_source ? (tb_pin_prev && !tmr_b_count_pin)
                                          : (tb_prescale == tb_div - 4'd1));

   // [R1] [R3] reload except in capture mode
   assign tb_step   = step16(tb_count, tb_reload, tb_mode != tb_capture);
   // [R24] one-cycle overflow event
   assign tb_ovf    = tb_tick && tb_step[16];
   assign trig_fall = trig_prev && !ext_trigger_pin;

   // Prescaler restarts while stopped so the first period is whole
   always_ff @(posedge sys_clk) begin
      if (reset || tb_mode == tb_stopped || tb_prescale >= tb_div - 4'd1) begin
         tb_prescale <= 4'h0;
      end else begin
         tb_prescale <= tb_prescale + 4'h1;
      end
   end

   // Pin samples for edge detection
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tb_pin_prev <= 1'b1;
         trig_prev   <= 1'b1;
         fast_prev   <= 1'b0;
         slow_prev   <= 1'b0;
      end else begin
         tb_pin_prev <= tmr_b_count_pin;
         trig_prev   <= ext_trigger_pin;
         fast_prev   <= fast_internal_osc;
         slow_prev   <= slow_internal_osc;
      end
   end

   // First timer count and reload/capture pair
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tb_count  <= 16'h0000;
         tb_reload <= 16'h0000;
      end else begin
         if (tb_tick) begin
            tb_count <= tb_step[15:0];
         end
         // [R8] trigger only acts when software enabled it
         if (trig_fall && tb_ctrl.ext_trigger_enable) begin
            // [R2] capture live count
            if (tb_mode == tb_capture) begin
               tb_reload <= tb_count;
            end else if (tb_mode == tb_auto_reload) begin
               tb_count <= tb_reload;
            end
         end
         // Software writes win over a same-cycle step on that byte
         if (wr && idx == `TMR_B_COUNT_LOW_IDX) begin
            tb_count[7:0] <= wbyte;
         end
         if (wr && idx == `TMR_B_COUNT_HIGH_IDX) begin
            tb_count[15:8] <= wbyte;
         end
         if (wr && idx == `TMR_B_RELOAD_LOW_IDX) begin
            tb_reload[7:0] <= wbyte;
         end
         if (wr && idx == `TMR_B_RELOAD_HIGH_IDX) begin
            tb_reload[15:8] <= wbyte;
         end
      end
   end

   // First timer control; hardware sets beat a same-cycle clear
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tb_ctrl    <= tmr_b_ctrl_t'(`REG_RESET_VALUE);
         tb_div_sel <= 1'b0;
      end else begin
         if (wr && idx == `TMR_B_CONTROL_IDX) begin
            tb_ctrl <= tmr_b_ctrl_t'(wbyte);
         end
         // [R5] no flag while used as baud source
         if (tb_ovf && tb_mode != tb_baud) begin
            tb_ctrl.overflow_flag <= 1'b1;
         end
         // [R7] trigger edge flag
         if (trig_fall && tb_ctrl.ext_trigger_enable) begin
            tb_ctrl.ext_trigger_flag <= 1'b1;
         end
         if (wr && idx == `TMR_B_DIVIDE_IDX) begin
            tb_div_sel <= wbyte[`TMR_B_DIVIDE_SEL_BIT];
         end
      end
   end

   // [R6] baud clock sources, registered
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rx_baud_tick <= 1'b0;
         tx_baud_tick <= 1'b0;
      end else begin
         rx_baud_tick <= tb_ctrl.rx_baud_source_sel ? (tb_ovf && tb_mode == tb_baud) : legacy_timer_overflow;
         tx_baud_tick <= tb_ctrl.tx_baud_source_sel ? (tb_ovf && tb_mode == tb_baud) : legacy_timer_overflow;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timers c and d

   tmr_simple_ctrl_t cd_sel [2];
   logic [16:0]      cd_step [2];
   logic             cd_ovf [2];
   logic [15:0]      cd_low_idx [2];

   assign cd_sel[0]     = cd_ctrl.c;
   assign cd_sel[1]     = cd_ctrl.d;
   assign cd_low_idx[0] = `TMR_C_COUNT_LOW_IDX;
   assign cd_low_idx[1] = `TMR_D_COUNT_LOW_IDX;

   // [R10] [R12] [R24] step, reload or wrap
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         cd_step[i] = step16(cd_count[i], cd_reload[i], cd_sel[i].mode);
         // [R13] advance only while running
         cd_ovf[i]  = cd_sel[i].run && cd_step[i][16];
      end
   end

   // Counters and reloads
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         for (int i = 0; i < 2; i++) begin
            cd_count[i]  <= 16'h0000;
            cd_reload[i] <= 16'h0000;
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (cd_sel[i].run) begin
               cd_count[i] <= cd_step[i][15:0];
            end
            // [R15] reload mode writes reload, free-run the counter
            if (wr && (idx == cd_low_idx[i] || idx == cd_low_idx[i] + 16'h0001)) begin
               if (cd_sel[i].mode) begin
                  cd_reload[i] <= put_byte16(cd_reload[i], wbyte, idx[0]);
               end else begin
                  cd_count[i] <= put_byte16(cd_count[i], wbyte, idx[0]);
               end
            end
         end
      end
   end

   // Shared control; overflow set wins over a same-cycle clear
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cd_ctrl <= tmr_c_d_ctrl_t'(`REG_RESET_VALUE);
      end else begin
         if (wr && idx == `TMR_C_D_CONTROL_IDX) begin
            cd_ctrl <= tmr_c_d_ctrl_t'(wbyte);
         end
         // [R11] hardware sets flags
         if (cd_ovf[0]) begin
            cd_ctrl.c.overflow_flag <= 1'b1;
         end
         if (cd_ovf[1]) begin
            cd_ctrl.d.overflow_flag <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timer e, 24 bits, oscillator edges

   logic        te_tick;
   logic        te_wrap;
   logic [23:0] te_next;
   logic        te_wr_hit;
   logic [1:0]  te_lane;

   // [R18] [R19] osc choice; each below half the system clock
   // Stop or sleep: counts only while the system clock runs
   assign te_tick   = te_ctrl.run &&
                      (te_ctrl.clock_sel[1] ? (slow_internal_osc && !slow_prev)
                                            : (fast_internal_osc && !fast_prev));
   assign te_wrap   = (te_count == 24'hffffff);
   // [R17] [R20] reload or wrap at all ones
   assign te_next   = te_wrap ? (te_ctrl.mode ? te_reload : 24'h000000) : te_count + 24'h000001;
   assign te_wr_hit = wr && (idx == `TMR_E_COUNT_LOW_IDX || idx == `TMR_E_COUNT_MID_IDX ||
                             idx == `TMR_E_COUNT_TOP_IDX);
   assign te_lane   = 2'(idx - `TMR_E_COUNT_LOW_IDX);

   // Count and reload
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         te_count  <= 24'h000000;
         te_reload <= 24'h000000;
      end else begin
         if (te_tick) begin
            te_count <= te_next;
         end
         // [R17] byte write by mode
         if (te_wr_hit) begin
            if (te_ctrl.mode) begin
               te_reload[te_lane*8 +: 8] <= wbyte;
            end else begin
               te_count[te_lane*8 +: 8] <= wbyte;
            end
         end
      end
   end

   // Control; reserved bits stay zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         te_ctrl <= tmr_e_ctrl_t'(`REG_RESET_VALUE);
      end else begin
         if (wr && idx == `TMR_E_CONTROL_IDX) begin
            te_ctrl <= tmr_e_ctrl_t'(wbyte & ~`TMR_E_RESERVED_MASK);
         end
         // [R11] [R20] hardware set of the flag
         if (te_tick && te_wrap) begin
            te_ctrl.overflow_flag <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt lines

   // [R14] [R25] flag gated by enable; timer b ORs its two flags, ungated
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq <= '0;
      end else begin
         irq.tmr_b_irq <= tb_ctrl.overflow_flag || tb_ctrl.ext_trigger_flag;
         irq.tmr_c_irq <= cd_ctrl.c.overflow_flag && cd_ctrl.c.irq_enable;
         irq.tmr_d_irq <= cd_ctrl.d.overflow_flag && cd_ctrl.d.irq_enable;
         irq.tmr_e_irq <= te_ctrl.overflow_flag && te_ctrl.irq_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux and answer

   // [R16] live counts, no snapshot
   always_comb begin
      mapped = 1'b1;
      rbyte  = 8'h00;
      case (idx)
         `TMR_B_CONTROL_IDX:     rbyte = tb_ctrl;
         `TMR_B_DIVIDE_IDX:      rbyte = {7'h00, tb_div_sel};
         `TMR_B_RELOAD_LOW_IDX:  rbyte = tb_reload[7:0];
         `TMR_B_RELOAD_HIGH_IDX: rbyte = tb_reload[15:8];
         `TMR_B_COUNT_LOW_IDX:   rbyte = tb_count[7:0];
         `TMR_B_COUNT_HIGH_IDX:  rbyte = tb_count[15:8];
         `TMR_C_COUNT_LOW_IDX:   rbyte = cd_count[0][7:0];
         `TMR_C_COUNT_HIGH_IDX:  rbyte = cd_count[0][15:8];
         `TMR_D_COUNT_LOW_IDX:   rbyte = cd_count[1][7:0];
         `TMR_D_COUNT_HIGH_IDX:  rbyte = cd_count[1][15:8];
         `TMR_C_D_CONTROL_IDX:   rbyte = cd_ctrl;
         `TMR_E_CONTROL_IDX:     rbyte = te_ctrl;
         `TMR_E_COUNT_LOW_IDX:   rbyte = te_count[7:0];
         `TMR_E_COUNT_MID_IDX:   rbyte = te_count[15:8];
         `TMR_E_COUNT_TOP_IDX:   rbyte = te_count[23:16];
         default:                mapped = 1'b0;
      endcase
      // Misaligned means unmapped
      if (apb_req.paddr[1:0] != 2'b00) begin
         mapped = 1'b0;
      end
   end

   // Zero-wait; unmapped access errors and changes nothing
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = access && !mapped;
   assign apb_rsp.prdata  = (access && mapped && !apb_req.pwrite) ? {24'h000000, rbyte} : 32'h00000000;

endmodule

//--- pkg/system_timers_regs.svh
`ifndef SYSTEM_TIMERS_REGS_SVH
`define SYSTEM_TIMERS_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices; byte address is four times the index
`define TMR_D_COUNT_LOW_IDX      16'h00ac
`define TMR_D_COUNT_HIGH_IDX     16'h00ad
`define TMR_C_COUNT_LOW_IDX      16'h00ae
`define TMR_C_COUNT_HIGH_IDX     16'h00af
`define TMR_B_CONTROL_IDX        16'h00c8
`define TMR_B_DIVIDE_IDX         16'h00c9
`define TMR_B_RELOAD_LOW_IDX     16'h00ca
`define TMR_B_RELOAD_HIGH_IDX    16'h00cb
`define TMR_B_COUNT_LOW_IDX      16'h00cc
`define TMR_B_COUNT_HIGH_IDX     16'h00cd
`define TMR_C_D_CONTROL_IDX      16'h00cf
`define TMR_E_CONTROL_IDX        16'ha003
`define TMR_E_COUNT_LOW_IDX      16'ha004
`define TMR_E_COUNT_MID_IDX      16'ha005
`define TMR_E_COUNT_TOP_IDX      16'ha006

////////////////////////////////////////////////////////////////////////////////
// Reset values and field positions
`define REG_RESET_VALUE          8'h00
`define TMR_B_DIVIDE_SEL_BIT     0
`define TMR_E_RESERVED_MASK      8'h06

////////////////////////////////////////////////////////////////////////////////
// First timer prescale ratios, in system clocks
`define TMR_B_DIV_STD            4'd12
`define TMR_B_DIV_FAST           4'd4
`define TMR_B_DIV_BAUD           4'd2

`endif

//--- pkg/system_timers_pkg.sv
package system_timers_pkg;

   // APB request from the CPU side
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [17:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   // APB answer to the CPU side
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_t;

   // First timer control byte, bit 7 first
   typedef struct packed {
      logic overflow_flag;
      logic ext_trigger_flag;
      logic rx_baud_source_sel;
      logic tx_baud_source_sel;
      logic ext_trigger_enable;
      logic run;
      logic count_source;
      logic capture_reload_sel;
   } tmr_b_ctrl_t;

   // One nibble of the shared control byte
   typedef struct packed {
      logic overflow_flag;
      logic mode;
      logic run;
      logic irq_enable;
   } tmr_simple_ctrl_t;

   // Shared control: d high nibble, c low
   typedef struct packed {
      tmr_simple_ctrl_t d;
      tmr_simple_ctrl_t c;
   } tmr_c_d_ctrl_t;

   // 24-bit timer control byte
   typedef struct packed {
      logic       overflow_flag;
      logic [1:0] clock_sel;
      logic       mode;
      logic       run;
      logic [1:0] reserved;
      logic       irq_enable;
   } tmr_e_ctrl_t;

   // Interrupt request lines
   typedef struct packed {
      logic tmr_b_irq;
      logic tmr_c_irq;
      logic tmr_d_irq;
      logic tmr_e_irq;
   } timer_irq_t;

   // Operating mode of the first timer
   typedef enum logic [1:0] {
      tb_stopped,
      tb_auto_reload,
      tb_capture,
      tb_baud
   } tmr_b_mode_t;

endpackage

//--- bench/system_timers_chk.sv
`timescale 1ns/1ps
`include "system_timers_regs.svh"
module system_timers_chk (
   // Clock and reset
   input wire logic                          sys_clk,
   input wire logic                          reset,
   // Register bus and serial ticks
   input wire system_timers_pkg::apb_req_t   apb_req,
   input wire logic                          legacy_timer_overflow,
   input wire logic                          rx_baud_tick,
   input wire logic                          tx_baud_tick,
   // Interrupt lines
   input wire system_timers_pkg::timer_irq_t irq
);
   import system_timers_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   tmr_b_ctrl_t   bctl;  // Shadow of first timer control
   tmr_c_d_ctrl_t cd;    // Shadow of shared control
   tmr_e_ctrl_t   ectl;  // Shadow of 24-bit control
   logic          wr_go; // Write taken at this edge
   logic          wr_cd; // Write to shared control
   assign wr_go = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign wr_cd = wr_go && apb_req.paddr == {`TMR_C_D_CONTROL_IDX, 2'b00};
   ////////////////////////////////////////////////////////////////////////////
   // Shadows of selects and enables
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bctl <= '0;
         cd   <= '0;
         ectl <= '0;
      end else if (wr_go) begin
         if (apb_req.paddr == {`TMR_B_CONTROL_IDX, 2'b00}) bctl <= apb_req.pwdata[7:0];
         if (wr_cd) cd <= apb_req.pwdata[7:0];
         if (apb_req.paddr == {`TMR_E_CONTROL_IDX, 2'b00}) ectl <= apb_req.pwdata[7:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   rx_legacy_a: assert property (!bctl.rx_baud_source_sel |=> rx_baud_tick == $past(legacy_timer_overflow))
      else $error("rx not legacy");
   tx_legacy_a: assert property (!bctl.tx_baud_source_sel |=> tx_baud_tick == $past(legacy_timer_overflow))
      else $error("tx not legacy");
   rx_stop_a: assert property ((bctl.rx_baud_source_sel && !bctl.run) [*3] |-> !rx_baud_tick)
      else $error("stopped ticks");
   rx_single_a: assert property (bctl.rx_baud_source_sel [*2] ##0 rx_baud_tick |=> !rx_baud_tick)
      else $error("tick too long");
   both_sel_a: assert property (bctl.rx_baud_source_sel && bctl.tx_baud_source_sel |=> rx_baud_tick == tx_baud_tick)
      else $error("rx tx differ");
   irq_c_gate_a: assert property (!cd.c.irq_enable |=> !irq.tmr_c_irq)
      else $error("c irq disabled");
   irq_e_gate_a: assert property (!ectl.irq_enable |=> !irq.tmr_e_irq)
      else $error("e irq disabled");
   irq_c_hold_a: assert property ($fell(irq.tmr_c_irq) && !$past(reset) |-> $past(wr_cd, 2))
      else $error("c irq dropped");
   // Main scenarios reached
   cover property (rx_baud_tick && bctl.rx_baud_source_sel);
   cover property ($rose(irq.tmr_c_irq));
   cover property ($rose(irq.tmr_e_irq));
endmodule

bind system_timers_two_to_five system_timers_chk u_chk (
   .sys_clk, .reset, .apb_req, .legacy_timer_overflow, .rx_baud_tick, .tx_baud_tick, .irq
);

//--- bench/cpu_apb_model.sv
`timescale 1ns/1ps
module cpu_apb_model (
   // Clock
   input wire logic                        sys_clk,
   // Bus towards the timers
   output     system_timers_pkg::apb_req_t apb_req,
   input wire system_timers_pkg::apb_rsp_t apb_rsp
);
   import system_timers_pkg::*;
   initial apb_req = '0;
   ////////////////////////////////////////////////////////////////////////////
   // One transfer, held until pready
   task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
      @(posedge sys_clk);
      apb_req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:{idx, 2'b00}, pwdata:{24'h0, wd}};
      @(posedge sys_clk);
      apb_req.penable <= 1'b1;
      @(posedge sys_clk);
      while (apb_rsp.pready !== 1'b1) @(posedge sys_clk);
      rd = apb_rsp.prdata[7:0];
      err = apb_rsp.pslverr;
      apb_req <= '0;
   endtask
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ps
`include "system_timers_regs.svh"
module tb_top;
   import system_timers_pkg::*;
   localparam logic [15:0] CD = `TMR_C_D_CONTROL_IDX, BC = `TMR_B_CONTROL_IDX, EC = `TMR_E_CONTROL_IDX,
      CL = `TMR_C_COUNT_LOW_IDX, CH = `TMR_C_COUNT_HIGH_IDX, DL = `TMR_D_COUNT_LOW_IDX,
      DH = `TMR_D_COUNT_HIGH_IDX, EL = `TMR_E_COUNT_LOW_IDX, ET = `TMR_E_COUNT_TOP_IDX,
      BL = `TMR_B_COUNT_LOW_IDX;
   logic        sys_clk, reset, cnt_pin, trig_pin, legacy, fast_osc, slow_osc;
   logic        rx_tick, tx_tick, err;
   logic [7:0]  rd, a;
   apb_req_t    apb_req;
   apb_rsp_t    apb_rsp;
   timer_irq_t  irq;
   int          err_total, samples_checked, ticks, cyc;
   // Reset sweep
   logic [15:0] regs [10] = '{DL, DH, CL, CH, BC, CD, EC, EL, `TMR_E_COUNT_MID_IDX, ET};

   system_timers_two_to_five DUT (.sys_clk, .reset, .apb_req, .apb_rsp,
      .tmr_b_count_pin(cnt_pin), .ext_trigger_pin(trig_pin), .legacy_timer_overflow(legacy),
      .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick), .fast_internal_osc(fast_osc),
      .slow_internal_osc(slow_osc), .irq);
   cpu_apb_model cpu (.sys_clk, .apb_req, .apb_rsp);

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Fast osc at a quarter rate, legacy pulse every 7th clock
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      fast_osc <= cyc[1];
      legacy <= (cyc % 7 == 0);
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      give_verdict();
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      cpu.xfer(1'b1, idx, d, rd, err);
   endtask
   task automatic rd_b(input logic [15:0] idx);
      cpu.xfer(1'b0, idx, 8'h00, rd, err);
   endtask
   task automatic ok(input logic c, input string m);
      samples_checked++;
      if (c !== 1'b1) begin
         err_total++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task automatic chk(input logic [15:0] idx, input logic [7:0] exp);
      rd_b(idx);
      ok(rd === exp && err === 1'b0, $sformatf("%h got %h not %h", idx, rd, exp));
   endtask
   // Pin pulses
   task automatic pins(input int n, input logic [1:0] sel);
      repeat (n) begin
         @(posedge sys_clk);
         cnt_pin <= ~sel[0];
         trig_pin <= ~sel[0];
         slow_osc <= sel[1];
         repeat (4) @(posedge sys_clk);
         cnt_pin <= 1'b1;
         trig_pin <= 1'b1;
         slow_osc <= 1'b0;
         repeat (4) @(posedge sys_clk);
      end
   endtask
   task automatic count_rx(input int n);
      ticks = 0;
      // Skip the tick launched at the write edge
      @(posedge sys_clk);
      repeat (n) begin
         @(posedge sys_clk);
         ticks += rx_tick;
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {reset, cnt_pin, trig_pin} = 3'b111;
      {legacy, fast_osc, slow_osc, cyc, err_total, samples_checked} = '0;
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      foreach (regs[i]) chk(regs[i], 8'h00);
      rd_b(16'h0001);
      ok(err === 1'b1, "unmapped not refused");
      // Timer c free-run near the top, then overflow
      wr(CH, 8'hff);
      wr(CL, 8'hf0);
      chk(CH, 8'hff);
      chk(CL, 8'hf0);
      wr(CD, 8'h03);
      repeat (20) @(posedge sys_clk);
      chk(CD, 8'h0b);
      ok(irq.tmr_c_irq === 1'b1, "c request missing");
      chk(CH, 8'h00);
      wr(CD, 8'h08);
      cpu.xfer(1'b0, CL, 8'h00, a, err);
      chk(CL, a);
      chk(CD, 8'h08);
      ok(irq.tmr_c_irq === 1'b0, "c request not masked");
      wr(CD, 8'h00);
      chk(CD, 8'h00);
      // Timer d: live load, then reload
      wr(DL, 8'hfe);
      wr(DH, 8'hff);
      wr(CD, 8'h40);
      wr(DL, 8'hf0);
      wr(DH, 8'hff);
      chk(DL, 8'hfe);
      wr(CD, 8'h60);
      repeat (20) @(posedge sys_clk);
      chk(DH, 8'hff);
      chk(CD, 8'he0);
      ok(irq.tmr_d_irq === 1'b0, "d request not masked");
      wr(CD, 8'h00);
      // Timer e: 24-bit wrap on the fast oscillator
      wr(ET, 8'hff);
      wr(`TMR_E_COUNT_MID_IDX, 8'hff);
      wr(EL, 8'hff);
      chk(ET, 8'hff);
      wr(EC, 8'h0f);
      repeat (12) @(posedge sys_clk);
      chk(EC, 8'h89);
      ok(irq.tmr_e_irq === 1'b1, "e request missing");
      // Every clock code; only the slow one is pulsed
      for (int s = 0; s < 4; s++) begin
         wr(EC, {1'b0, s[1:0], 5'b01000});
         cpu.xfer(1'b0, EL, 8'h00, a, err);
         pins(3, 2'b10);
         rd_b(EL);
         ok(s[1] ? rd === a + 8'd3 : rd !== a, "osc select wrong");
      end
      // Timer b: auto-reload at divide 12
      wr(`TMR_B_RELOAD_LOW_IDX, 8'hf0);
      wr(`TMR_B_RELOAD_HIGH_IDX, 8'hff);
      wr(BL, 8'hfe);
      wr(`TMR_B_COUNT_HIGH_IDX, 8'hff);
      wr(BC, 8'h04);
      repeat (40) @(posedge sys_clk);
      chk(BC, 8'h84);
      ok(irq.tmr_b_irq === 1'b1, "b request missing");
      chk(`TMR_B_COUNT_HIGH_IDX, 8'hff);
      // Pin events, trigger kept disabled
      wr(BC, 8'h06);
      cpu.xfer(1'b0, BL, 8'h00, a, err);
      pins(3, 2'b01);
      chk(BL, a + 8'd3);
      chk(BC, 8'h06);
      // Baud mode: reload of all ones, then a tick every other clock
      wr(`TMR_B_RELOAD_LOW_IDX, 8'hff);
      wr(`TMR_B_RELOAD_HIGH_IDX, 8'hff);
      wr(BC, 8'h34);
      // Let the count reach its first overflow
      repeat (30) @(posedge sys_clk);
      count_rx(50);
      ok(ticks == 25, "baud tick rate wrong");
      chk(BC, 8'h34);
      wr(BC, 8'h30);
      count_rx(20);
      ok(ticks == 0, "stopped timer ticks");
      wr(BC, 8'h00);
      count_rx(70);
      ok(ticks == 10, "legacy ticks lost");
      give_verdict();
   end
endmodule
